// ### core/safety_output_interlock.sv
// safety output interlock: four semiconductor outputs, status output, probe bits, relays
// registers over a plain strobe port; pins taken synchronous to clk_sys_i
`timescale 1ns/100ps
module safety_output_interlock
  import safety_output_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned BLINK_MS = LED_BLINK_MS
)(
  input  wire logic                     clk_sys_i,
  input  wire logic                     nrst_i,
  input  wire logic [7:0]               addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [31:0]              rdata_o,
  input  wire logic [NUM_CH-1:0]        out_in_i,
  input  wire logic [NUM_CH-1:0]        restart_feedback_input_i,
  input  wire logic [NUM_CH-1:0]        contactor_feedback_i,
  output logic      [NUM_CH-1:0]        safety_switching_output_o,
  output logic      [NUM_CH-1:0]        out_status_o,
  output logic      [NUM_CH-1:0]        error_out_o,
  output logic      [NUM_CH/2-1:0]      output_clear_indicator_o,
  input  wire logic                     status_in_i,
  output logic                          status_out_o,
  input  wire logic [PROBE_MAX_NEW-1:0] probe_in_i,
  output logic      [PROBE_MAX_NEW-1:0] probe_bits_o,
  input  wire logic [NUM_RELAY-1:0]     relay_in_i,
  input  wire logic [NUM_RELAY-1:0]     relay_restart_i,
  input  wire logic [NUM_RELAY-1:0]     relay_internal_fb_i,
  input  wire logic [NUM_RELAY-1:0]     relay_ext_fb_i,
  output logic      [NUM_RELAY-1:0]     relay_close_o,
  output logic      [NUM_RELAY-1:0]     output_test_flag_o,
  input  wire logic                     master_reset_operator_i,
  input  wire logic                     internal_error_i
);

  localparam int unsigned TICK_W = $clog2(TICK_DIV + 1);
  localparam int unsigned BLNK_W = $clog2(BLINK_MS + 1);

  initial
  begin
    if (TICK_DIV < 1) $error("safety_output_interlock: TICK_DIV must be at least 1");
    if (BLINK_MS < 1) $error("safety_output_interlock: BLINK_MS must be at least 1");
    // group layouts, status word and relay config word are packed for four of each
    if (NUM_CH != 4) $error("safety_output_interlock: four output channels required");
    if (NUM_RELAY != 4) $error("safety_output_interlock: four relays required");
    if (CFG_WIN_LSB + CFG_WIN_W > 32) $error("safety_output_interlock: window field too wide");
    if (PROBE_MAX_OLD > PROBE_MAX_NEW) $error("safety_output_interlock: probe counts swapped");
  end

  logic [31:0]              ch_cfg [NUM_CH];
  logic [1:0]               group_cfg;
  logic [31:0]              relay_cfg;
  logic                     probe_newfw;
  logic [PROBE_MAX_NEW-1:0] probe_sel;
  logic                     clear;
  logic [TICK_W-1:0]        tick_cnt;
  logic                     tick;
  logic [BLNK_W-1:0]        blink_cnt;
  logic                     blink;
  logic [NUM_CH-1:0]        ch_in;
  logic [NUM_CH-1:0]        ch_out;
  logic [NUM_CH-1:0]        ch_fault;
  logic [NUM_CH-1:0]        ch_restart;
  logic [NUM_CH-1:0]        pair_double;
  logic [NUM_RELAY-1:0]     rl_out;
  logic [NUM_RELAY-1:0]     rl_fault;
  logic [NUM_RELAY-1:0]     rl_int_fault;
  logic [NUM_RELAY-1:0]     err_latch;

  // master reset operator or control register acts as synchronous clear
  assign clear = master_reset_operator_i || (wr_i && addr_i == ADDR_CONTROL
                 && wdata_i[CTRL_MRESET_BIT]);

  // register writes
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
        ch_cfg[i] <= CH_CFG_RST;
      group_cfg   <= GROUP_CFG_RST;
      relay_cfg   <= RELAY_CFG_RST;
      probe_newfw <= 1'b0;
      probe_sel   <= '0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        ADDR_CH_CFG0:   ch_cfg[0]   <= wdata_i;
        ADDR_CH_CFG1:   ch_cfg[1]   <= wdata_i;
        ADDR_CH_CFG2:   ch_cfg[2]   <= wdata_i;
        ADDR_CH_CFG3:   ch_cfg[3]   <= wdata_i;
        ADDR_GROUP_CFG: group_cfg   <= wdata_i[1:0];
        ADDR_RELAY_CFG: relay_cfg   <= wdata_i;
        ADDR_PROBE_CFG: probe_newfw <= wdata_i[PROBE_NEWFW_BIT];
        ADDR_PROBE_DATA: probe_sel  <= wdata_i;
        default: ;
      endcase
    end
  end

  // register reads, data in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      case (addr_i)
        ADDR_CH_CFG0:    rdata_o <= ch_cfg[0];
        ADDR_CH_CFG1:    rdata_o <= ch_cfg[1];
        ADDR_CH_CFG2:    rdata_o <= ch_cfg[2];
        ADDR_CH_CFG3:    rdata_o <= ch_cfg[3];
        ADDR_GROUP_CFG:  rdata_o <= {30'h0, group_cfg};
        ADDR_RELAY_CFG:  rdata_o <= relay_cfg;
        ADDR_PROBE_CFG:  rdata_o <= {31'h0, probe_newfw};
        ADDR_STATUS:     rdata_o <= {8'h0, output_test_flag_o, relay_close_o,
                                     err_latch, error_out_o, ch_fault, ch_out};
        ADDR_PROBE_DATA: rdata_o <= probe_bits_o;
        default:         rdata_o <= 32'h0000_0000;
      endcase
    end
    else
      rdata_o <= 32'h0000_0000;
  end

  // millisecond time base
  // a clear restarts it, so a window that starts at the clear begins on a whole tick
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (clear)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_W'(TICK_DIV - 1))
    begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end
    else if (clear)
    begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end
    else if (tick)
    begin
      if (blink_cnt == BLNK_W'(BLINK_MS - 1))
      begin
        blink_cnt <= '0;
        blink     <= !blink;
      end
      else
        blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // group layout: a double pair takes its input and restart from the pair's first channel
  always_comb
  begin
    case (group_cfg)
      GRP_TWO_DOUBLE: pair_double = 4'b1111;
      GRP_MIXED:      pair_double = 4'b1100;
      default:        pair_double = 4'b0000;
    endcase
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (pair_double[i] && i[0])
      begin
        ch_in[i]      = out_in_i[i-1];
        ch_restart[i] = restart_feedback_input_i[i-1];
      end
      else
      begin
        ch_in[i]      = out_in_i[i];
        // the restart pin is only meaningful when manual or feedback check is on
        ch_restart[i] = (ch_cfg[i][CFG_MANUAL_BIT] || ch_cfg[i][CFG_KCHECK_BIT])
                        && restart_feedback_input_i[i];
      end
    end
  end

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    output_channel #(
      .WIN_W (CFG_WIN_W)
    ) u_ch (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .clear_i     (clear),
      .tick_i      (tick),
      .in_i        (ch_in[g]),
      .manual_i    (ch_cfg[g][CFG_MANUAL_BIT]),
      .monitored_i (ch_cfg[g][CFG_MONITOR_BIT]),
      .kcheck_i    (ch_cfg[g][CFG_KCHECK_BIT]),
      .window_ms_i (ch_cfg[g][CFG_WIN_LSB +: CFG_WIN_W]),
      .restart_i   (ch_restart[g]),
      .feedback_i  (contactor_feedback_i[g]),
      .out_o       (ch_out[g]),
      .fault_o     (ch_fault[g])
    );
  end

  // a double pair switches off both channels if either one faults
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (pair_double[i])
        safety_switching_output_o[i] = ch_out[i & ~1] && ch_out[i | 1]
                                       && !ch_fault[i & ~1] && !ch_fault[i | 1];
      else
        safety_switching_output_o[i] = ch_out[i];
      out_status_o[i] = ch_cfg[i][CFG_STATUS_BIT] && safety_switching_output_o[i];
      error_out_o[i]  = ch_cfg[i][CFG_ERROUT_BIT] && ch_fault[i];
    end
    for (int p = 0; p < NUM_CH / 2; p++)
      output_clear_indicator_o[p] = (ch_fault[2*p] || ch_fault[2*p+1]) ? blink
                                    : (safety_switching_output_o[2*p]
                                       || safety_switching_output_o[2*p+1]);
  end

  assign status_out_o = status_in_i;

  // old firmware exposes only the low two bytes
  always_comb
  begin
    for (int b = 0; b < PROBE_MAX_NEW; b++)
      probe_bits_o[b] = probe_sel[b] && probe_in_i[b]
                        && (probe_newfw || b < PROBE_MAX_OLD);
  end

  // relay outputs: one config byte per relay: bit0 manual, bit1 monitored, bits3:2 category,
  // bit4 external feedback enable in category two (category four always checks, category one never), bits7:5 window in ms
  for (genvar r = 0; r < NUM_RELAY; r++)
  begin : g_rl
    logic [1:0] cat;
    logic       man;
    logic       mon;
    logic       kchk;
    logic [2:0] win;
    assign cat  = relay_cfg[8*r+2 +: 2];
    assign mon  = relay_cfg[8*r+1];
    assign win  = relay_cfg[8*r+5 +: 3];
    // intermediate category drops manual restart when feedback is watched
    assign man  = relay_cfg[8*r] && !(cat == RCAT_TWO && relay_cfg[8*r+4]);
    assign kchk = (cat == RCAT_FOUR) || (cat == RCAT_TWO && relay_cfg[8*r+4]);

    output_channel #(
      .WIN_W (3)
    ) u_rl (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .clear_i     (clear),
      .tick_i      (tick),
      .in_i        (relay_in_i[r]),
      .manual_i    (man),
      .monitored_i (mon),
      .kcheck_i    (kchk),
      .window_ms_i (win),
      .restart_i   (relay_restart_i[r]),
      .feedback_i  (relay_ext_fb_i[r]),
      .out_o       (rl_out[r]),
      .fault_o     (rl_fault[r])
    );

    // internal relay contact must match the coil drive in the same cycle
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
        rl_int_fault[r] <= 1'b0;
      else if (clear)
        rl_int_fault[r] <= 1'b0;
      else if (relay_internal_fb_i[r] != relay_close_o[r])
        rl_int_fault[r] <= 1'b1;
    end
  end

  // relay errors have no pin of their own; software reads them in the status word
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      err_latch <= '0;
    else if (clear)
      err_latch <= '0;
    else
      err_latch <= err_latch | rl_fault;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      relay_close_o      <= '0;
      output_test_flag_o <= '0;
    end
    else
    begin
      relay_close_o      <= rl_out & ~rl_fault & ~rl_int_fault;
      output_test_flag_o <= ~(rl_fault | rl_int_fault | {NUM_RELAY{internal_error_i}});
    end
  end

endmodule

// ### core/safety_output_pkg.sv
// package for the safety output interlock: register map, field positions, resets, timing
// assumes a 100 MHz system clock and a millisecond time base for all windows
package safety_output_pkg;

  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned TICK_PERIOD_MS    = 1;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_PERIOD_MS;

  localparam int unsigned NUM_CH            = 4;
  localparam int unsigned NUM_RELAY         = 4;
  localparam int unsigned PROBE_MAX_NEW     = 32;
  localparam int unsigned PROBE_MAX_OLD     = 16;
  localparam int unsigned PROBE_BYTES_NEW   = 4;
  localparam int unsigned PROBE_BYTES_OLD   = 2;

  localparam logic [7:0] ADDR_CH_CFG0       = 8'h00;
  localparam logic [7:0] ADDR_CH_CFG1       = 8'h04;
  localparam logic [7:0] ADDR_CH_CFG2       = 8'h08;
  localparam logic [7:0] ADDR_CH_CFG3       = 8'h0C;
  localparam logic [7:0] ADDR_GROUP_CFG     = 8'h10;
  localparam logic [7:0] ADDR_RELAY_CFG     = 8'h14;
  localparam logic [7:0] ADDR_PROBE_CFG     = 8'h18;
  localparam logic [7:0] ADDR_STATUS        = 8'h20;
  localparam logic [7:0] ADDR_PROBE_DATA    = 8'h24;
  localparam logic [7:0] ADDR_CONTROL       = 8'h28;

  localparam int unsigned CFG_MANUAL_BIT    = 0;
  localparam int unsigned CFG_MONITOR_BIT   = 1;
  localparam int unsigned CFG_STATUS_BIT    = 2;
  localparam int unsigned CFG_KCHECK_BIT    = 3;
  localparam int unsigned CFG_ERROUT_BIT    = 4;
  localparam int unsigned CFG_WIN_LSB       = 8;
  localparam int unsigned CFG_WIN_W         = 8;

  localparam int unsigned CTRL_MRESET_BIT   = 0;
  localparam int unsigned PROBE_NEWFW_BIT   = 0;

  localparam logic [31:0] CH_CFG_RST        = 32'h0000_0000;
  localparam logic [1:0]  GROUP_CFG_RST     = 2'h0;
  localparam logic [31:0] RELAY_CFG_RST     = 32'h0000_0000;

  // output group layouts
  localparam logic [1:0] GRP_FOUR_SINGLE    = 2'h0;
  localparam logic [1:0] GRP_TWO_DOUBLE     = 2'h1;
  localparam logic [1:0] GRP_MIXED          = 2'h2;

  // relay categories
  localparam logic [1:0] RCAT_ONE           = 2'h0;
  localparam logic [1:0] RCAT_TWO           = 2'h1;
  localparam logic [1:0] RCAT_FOUR          = 2'h2;

  localparam int unsigned LED_BLINK_MS      = 250;

  typedef enum logic [1:0] {
    RS_ARMED   = 2'b00,
    RS_WAIT_HI = 2'b01,
    RS_WAIT_LO = 2'b10,
    RS_RUN     = 2'b11
  } restart_state_e;

endpackage

// ### core/output_channel.sv
// one safety output channel: restart gate and contactor feedback window check
// assumes a one-cycle millisecond tick and synchronous pin inputs
`timescale 1ns/100ps
module output_channel
  import safety_output_pkg::*;
#(
  parameter int unsigned WIN_W = 8
)(
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic             clear_i,
  input  wire logic             tick_i,
  input  wire logic             in_i,
  input  wire logic             manual_i,
  input  wire logic             monitored_i,
  input  wire logic             kcheck_i,
  input  wire logic [WIN_W-1:0] window_ms_i,
  input  wire logic             restart_i,
  input  wire logic             feedback_i,
  output logic                  out_o,
  output logic                  fault_o
);

  restart_state_e state;
  restart_state_e next_state;
  logic             restart_q;
  logic             out_q;
  logic [WIN_W-1:0] win_cnt;
  logic             enable;

  initial
  begin
    if (WIN_W < 1 || WIN_W > 16) $error("output_channel: WIN_W out of range");
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      restart_q <= 1'b0;
    end
    else
    begin
      restart_q <= restart_i;
    end
  end

  // a falling input re-arms the restart request
  always_comb
  begin
    next_state = state;
    case (state)
      RS_ARMED:
        if (in_i && restart_i && !restart_q)
          next_state = monitored_i ? RS_WAIT_LO : RS_RUN;
      RS_WAIT_LO:
        if (!in_i)
          next_state = RS_ARMED;
        else if (!restart_i)
          next_state = RS_RUN;
      RS_WAIT_HI:
        next_state = RS_ARMED;
      RS_RUN:
        if (!in_i)
          next_state = RS_ARMED;
      default:
        next_state = RS_ARMED;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state <= RS_ARMED;
    else if (clear_i)
      state <= RS_ARMED;
    else
      state <= next_state;
  end

  assign enable = manual_i ? (state == RS_RUN) && in_i : in_i;

  // the feedback must reach the opposite level of the output inside the window
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      win_cnt <= '0;
      fault_o <= 1'b0;
    end
    else if (clear_i)
    begin
      win_cnt <= '0;
      fault_o <= 1'b0;
    end
    else if (!kcheck_i || (feedback_i != out_q) || (enable != out_q))
      win_cnt <= '0;
    else if (tick_i)
    begin
      if (win_cnt >= window_ms_i)
        fault_o <= 1'b1;
      else
        win_cnt <= win_cnt + 1'b1;
    end
  end

  // a fault forces the output low until cleared
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      out_q <= 1'b0;
    else
      out_q <= enable && !fault_o && !clear_i;
  end

  assign out_o = out_q;

endmodule

// ### bench/contactor_model.sv
// external contactors with feedback contacts, one per driven output
// assumes drive levels change on clk_sys_i; a stuck channel echoes its drive instead
`timescale 1ns/100ps
module contactor_model #(
  parameter int unsigned FAST = 2,
  parameter int unsigned SLOW = 8
)(
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] drive_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] stuck_i,
  output logic      [3:0] feedback_o
);
  logic [7:0][3:0] hist;

  always_ff @(posedge clk_sys_i)
    hist <= {hist[6:0], drive_i};

  // mirror contact opposes the coil only once the armature has moved, on make and on break
  always_comb
    for (int i = 0; i < 4; i++)
      feedback_o[i] = stuck_i[i] ? drive_i[i] : ~hist[slow_i ? SLOW - 1 : FAST - 1][i];
endmodule

// ### bench/safety_output_monitor.sv
// concurrent checks on the ports of the safety output interlock
// assumes one clock domain and nrst_i active low
`timescale 1ns/100ps
module safety_output_monitor
  import safety_output_pkg::*;
(
  input wire logic                     clk_sys_i,
  input wire logic                     nrst_i,
  input wire logic                     wr_i,
  input wire logic [NUM_CH-1:0]        out_in_i,
  input wire logic [NUM_CH-1:0]        safety_switching_output_o,
  input wire logic [NUM_CH-1:0]        out_status_o,
  input wire logic [NUM_CH-1:0]        error_out_o,
  input wire logic                     status_in_i,
  input wire logic                     status_out_o,
  input wire logic [PROBE_MAX_NEW-1:0] probe_in_i,
  input wire logic [PROBE_MAX_NEW-1:0] probe_bits_o,
  input wire logic [NUM_RELAY-1:0]     relay_in_i,
  input wire logic [NUM_RELAY-1:0]     relay_close_o,
  input wire logic [NUM_RELAY-1:0]     output_test_flag_o,
  input wire logic                     master_reset_operator_i,
  input wire logic                     internal_error_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_in_low_off: assert property (!out_in_i[0] |=> !safety_switching_output_o[0])
    else $error("output 0 on after its input was low");
  chk_err_forces_off: assert property (error_out_o[0] |=> !safety_switching_output_o[0])
    else $error("output 0 on while its error was set");
  // a control write may take one extra cycle to reach the latch
  chk_err_held: assert property ($fell(error_out_o[0]) |->
    $past(master_reset_operator_i) || $past(wr_i) || $past(wr_i, 2))
    else $error("error output dropped without a clear");
  chk_mreset_clears: assert property (master_reset_operator_i |=> error_out_o == 4'h0)
    else $error("error output survived the reset operator");
  chk_status_mirror: assert property (status_out_o == status_in_i)
    else $error("status output differs from its input");
  chk_status_gated: assert property ((out_status_o & ~safety_switching_output_o) == 4'h0)
    else $error("status shows an output that is off");
  chk_probe_subset: assert property ($stable(probe_in_i) |->
    (probe_bits_o & ~probe_in_i) == 32'h0000_0000)
    else $error("probe bit set without its point");
  chk_relay_open: assert property (!relay_in_i[0] [*2] |=> !relay_close_o[0])
    else $error("relay 0 closed with its input low");
  chk_flag_on_error: assert property (internal_error_i |=> output_test_flag_o == 4'h0)
    else $error("test flag stayed up on internal error");
endmodule

bind safety_output_interlock safety_output_monitor mon (
  .clk_sys_i, .nrst_i, .wr_i, .out_in_i, .safety_switching_output_o, .out_status_o,
  .error_out_o, .status_in_i, .status_out_o, .probe_in_i, .probe_bits_o, .relay_in_i,
  .relay_close_o, .output_test_flag_o, .master_reset_operator_i, .internal_error_i
);

// ### bench/safety_output_interlock_test.sv
// self-checking bench for the safety output interlock
// assumes the contactor model answers both the safety outputs and the relays
`timescale 1ns/100ps
module safety_output_interlock_test;
  import safety_output_pkg::*;
  localparam int unsigned TDIV = 4;
  localparam int unsigned BMS  = 2;
  logic        clk_sys_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, probe_in_i = 32'h0, rdata_o, probe_bits_o, r, m;
  logic [3:0]  out_in_i = 4'h0, restart_feedback_input_i = 4'h0, relay_in_i = 4'h0;
  logic [3:0]  relay_restart_i = 4'h0, stuck = 4'h0, contactor_feedback_i, relay_ext_fb_i;
  logic [3:0]  safety_switching_output_o, out_status_o, error_out_o, relay_internal_fb_i;
  logic [3:0]  relay_close_o, output_test_flag_o, int_bad = 4'h0;
  logic [3:0]  exp_q [$];
  logic [1:0]  output_clear_indicator_o, seen;
  logic        status_in_i = 1'b0, master_reset_operator_i = 1'b0, internal_error_i = 1'b0;
  logic        status_out_o, slow = 1'b0;
  logic [31:0] seed = 32'h0000_D35F;
  logic [3:0]  grp_exp [3] = '{4'h5, 4'hF, 4'hD};
  logic [2:0]  mt [9] = '{3'h0, 3'h4, 3'h7, 3'h0, 3'h4, 3'h7, 3'h0, 3'h6, 3'h5};
  int          err_count = 0, total_checks = 0;

  safety_output_interlock #(.TICK_DIV(TDIV), .BLINK_MS(BMS)) dut (
    .clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .out_in_i,
    .restart_feedback_input_i, .contactor_feedback_i, .safety_switching_output_o,
    .out_status_o, .error_out_o, .output_clear_indicator_o, .status_in_i, .status_out_o,
    .probe_in_i, .probe_bits_o, .relay_in_i, .relay_restart_i, .relay_internal_fb_i,
    .relay_ext_fb_i, .relay_close_o, .output_test_flag_o, .master_reset_operator_i,
    .internal_error_i
  );
  contactor_model ck (.clk_sys_i, .drive_i(safety_switching_output_o), .slow_i(slow),
    .stuck_i(stuck), .feedback_o(contactor_feedback_i));
  contactor_model rk (.clk_sys_i, .drive_i(relay_close_o), .slow_i(slow),
    .stuck_i(4'h0), .feedback_o(relay_ext_fb_i));
  // internal relay contacts follow the drive; int_bad breaks one to inject a contact fault
  assign relay_internal_fb_i = relay_close_o ^ int_bad;

  initial
    forever #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp, "read");
  endtask

  task automatic step(input logic [3:0] in, input logic [3:0] rs, input int n,
                      input logic [3:0] exp);
    @(posedge clk_sys_i);
    out_in_i <= in;
    restart_feedback_input_i <= rs;
    cyc(n);
    chk({28'h0, safety_switching_output_o}, {28'h0, exp}, "output");
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(ADDR_CH_CFG0, CH_CFG_RST);
    rd(ADDR_GROUP_CFG, {30'h0, GROUP_CFG_RST});
    rd(ADDR_RELAY_CFG, RELAY_CFG_RST);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0000_0000);
    done("registers");
    for (int c = 0; c < NUM_CH; c++)
      wr(8'(4 * c), 32'h0000_0004);
    for (int i = 0; i < 30; i++)
    begin
      r = xs();
      exp_q.push_back(r[3:0]);
      @(posedge clk_sys_i) status_in_i <= r[4];
      step(r[3:0], 4'h0, 1, exp_q[0]);
      chk({28'h0, out_status_o}, {28'h0, exp_q.pop_front()}, "status");
      chk({31'h0, status_out_o}, {31'h0, r[4]}, "mirror");
    end
    done("follow");
    for (int g = 0; g < 3; g++)
    begin
      wr(ADDR_GROUP_CFG, 32'(g));
      rd(ADDR_GROUP_CFG, 32'(g));
      step(4'h5, 4'h0, 2, grp_exp[g]);
    end
    wr(ADDR_GROUP_CFG, 32'h0);
    done("groups");
    wr(ADDR_CH_CFG0, 32'h0000_0001);
    for (int i = 0; i < 9; i++)
    begin
      if (i == 6)
        wr(ADDR_CH_CFG0, 32'h0000_0003);
      step({3'h0, mt[i][2]}, {3'h0, mt[i][1]}, 3, {3'h0, mt[i][0]});
    end
    done("restart");
    wr(ADDR_CH_CFG0, 32'h0000_0418);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk_sys_i) slow <= 1'(s);
      step(4'h0, 4'h0, 12, 4'h0);
      step(4'h1, 4'h0, 40, 4'h1);
      chk({28'h0, error_out_o}, 32'h0, "no fault");
    end
    @(posedge clk_sys_i) stuck <= 4'h1;
    cyc(30);
    chk({28'h0, error_out_o}, 32'h1, "error out");
    chk({28'h0, safety_switching_output_o}, 32'h0, "forced off");
    seen = 2'b00;
    repeat (4 * BMS * TDIV)
    begin
      @(posedge clk_sys_i) #1 seen[output_clear_indicator_o[0]] = 1'b1;
    end
    chk({30'h0, seen}, 32'h3, "blink");
    @(posedge clk_sys_i) stuck <= 4'h0;
    cyc(20);
    chk({28'h0, error_out_o}, 32'h1, "latched");
    @(posedge clk_sys_i) master_reset_operator_i <= 1'b1;
    @(posedge clk_sys_i) master_reset_operator_i <= 1'b0;
    #1;
    chk({28'h0, error_out_o}, 32'h0, "operator clear");
    wr(ADDR_CH_CFG0, 32'h0000_0408);
    @(posedge clk_sys_i) stuck <= 4'h1;
    cyc(30);
    chk({28'h0, error_out_o}, 32'h0, "error disabled");
    chk({28'h0, safety_switching_output_o}, 32'h0, "forced off");
    @(posedge clk_sys_i) stuck <= 4'h0;
    wr(ADDR_CONTROL, 32'h1 << CTRL_MRESET_BIT);
    step(4'h1, 4'h0, 12, 4'h1);
    done("feedback");
    wr(ADDR_RELAY_CFG, 32'h0000_0000);
    for (int i = 0; i < 12; i++)
    begin
      r = xs();
      @(posedge clk_sys_i) relay_in_i <= r[3:0];
      cyc(2);
      chk({28'h0, relay_close_o}, {28'h0, r[3:0]}, "relay");
      chk({28'h0, output_test_flag_o}, 32'hF, "test flag");
    end
    wr(ADDR_RELAY_CFG, 32'h0000_0001);
    @(posedge clk_sys_i) relay_in_i <= 4'h0;
    @(posedge clk_sys_i) relay_in_i <= 4'h1;
    cyc(4);
    chk({31'h0, relay_close_o[0]}, 32'h0, "relay manual");
    @(posedge clk_sys_i) relay_restart_i <= 4'h1;
    cyc(4);
    chk({31'h0, relay_close_o[0]}, 32'h1, "relay restarted");
    @(posedge clk_sys_i) relay_restart_i <= 4'h0;
    wr(ADDR_RELAY_CFG, 32'h0000_0095);
    @(posedge clk_sys_i) relay_in_i <= 4'h0;
    cyc(12);
    @(posedge clk_sys_i) relay_in_i <= 4'h1;
    cyc(12);
    chk({31'h0, relay_close_o[0]}, 32'h1, "forced auto");
    chk({31'h0, output_test_flag_o[0]}, 32'h1, "monitored flag");
    @(posedge clk_sys_i) internal_error_i <= 1'b1;
    cyc(2);
    chk({28'h0, output_test_flag_o}, 32'h0, "flag drop");
    @(posedge clk_sys_i) internal_error_i <= 1'b0;
    @(posedge clk_sys_i) int_bad <= 4'h2;
    cyc(3);
    chk({28'h0, output_test_flag_o}, 32'hD, "internal contact");
    done("relays");
    for (int f = 0; f < 2; f++)
    begin
      r = xs();
      m = xs();
      wr(ADDR_PROBE_CFG, 32'(f));
      wr(ADDR_PROBE_DATA, m);
      @(posedge clk_sys_i) probe_in_i <= r;
      cyc(2);
      chk(probe_bits_o, r & m & (f == 1 ? 32'hFFFF_FFFF : 32'h0000_FFFF), "probes");
    end
    done("probes");
    report_and_stop();
  end
endmodule
